// file: hw/led_dim_defines.svh
// Constants for the LED matrix dimming core: register map, field
// positions, reset values and scan timing.
// Assumes it is included by its bare name; definitions only.
`ifndef LED_DIM_DEFINES_SVH
`define LED_DIM_DEFINES_SVH
`define DOTS 351
`define NCOL 39
`define NROW 9
`define NCOL_W 9'h027
`define DOTS_A 9'h0b4
`define LAST_A 8'hb3
`define LAST_B 8'haa
`define PG_DUTY_A 3'h0
`define PG_DUTY_B 3'h1
`define PG_SCL_A 3'h2
`define PG_SCL_B 3'h3
`define PG_FN 3'h4
`define A_CFG 8'h00
`define A_GCC 8'h01
`define A_PULL 8'h02
`define A_RES_LO 8'h03
`define A_RES_HI 8'h2f
`define A_RESET 8'h3f
`define A_PAGE 8'hfd
`define A_UNLOCK 8'hfe
`define RESET_KEY 8'hae
`define UNLOCK_KEY 8'hc5
`define CFG_RST 8'h00
`define GCC_RST 8'h00
`define PULL_RST 8'h55
`define PULL_MASK 8'h77
`define CFG_RUN 0
`define CFG_DET 2:1
`define CFG_THR 3
`define CFG_SWS 7:4
`define PULL_DN 6:4
`define PULL_UP 2:0
`define DET_OFF 2'h0
`define DET_SHORT 2'h2
`define SWS_STEADY 4'h8
`define SWS_MAX 4'h7
`define RES_PER_ROW 8'h05
`define RES_TAIL 3'h4
`define CLK_NS 5
`define T_SCAN_NS 32000
`define T_NOL_NS 2000
`define PWM_STEPS 256
`endif

// file: hw/led_dim_pkg.sv
// Types shared by the LED matrix dimming core and its scan sequencer.
// Assumes led_dim_defines.svh is on the include path.
package led_dim_pkg;
`include "led_dim_defines.svh"
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_GAP1 = 4'b0010,
    S_SLOT = 4'b0100,
    S_GAP2 = 4'b1000
  } scan_state_t;

  typedef struct packed {
    scan_state_t state;
    logic [15:0] cnt;
    logic [7:0] step;
    logic [3:0] row;
    logic [8:0] sw;
  } scan_t;

  typedef struct packed {
    logic [2:0] page;
    logic [7:0] unlock;
    logic [7:0] cfg;
    logic [7:0] global_current;
    logic [7:0] pull;
    logic [`DOTS-1:0] fault;
    logic armed;
    logic start;
    logic [7:0] rdata;
    logic [`NCOL-1:0] sink;
    logic [`NCOL*8-1:0] cur;
  } regs_t;
endpackage

// file: hw/led_matrix_dimming_regs.sv
// Register file and dimming core of a 39 x 9 LED matrix driver.
// Assumes a byte register port behind the serial host link, and an
// analog front end that accepts sink, switch and current codes.
//
// Summary of operation
// - One duty byte per dot on pages 0 and 1, reset zero.
// - Dot on-time is duty over 256, one pulse from slot start.
// - Each row gets 32 us slot plus two 2 us gaps.
// - One scaling byte per dot on pages 2 and 3, reset zero.
// - Peak sink current is scaling byte times global current over 256.
// - Accesses go to the page chosen by the page select register.
// - Function bytes 03h to 2Fh read detection results, reset zero.
// - Config bit 0 zero means shutdown, one means running.
// - Detect field 00 off, 01 or 11 open, 10 short.
// - Detection runs once; field must return to 00 to rerun.
// - Config bit 3 selects low or high input threshold set.
// - Row count code 0 scans nine rows, 1 to 7 fewer.
// - Code 8 drives sinks steadily without scan; others scan nine.
// - Global current byte at 01h scales all sinks, reset zero.
// - Pull code fields at bits 6:4 and 2:0, each reset 101.
// - Writing AEh to reset register restores every default, except a fault result arriving in that same cycle, which is kept.
// - Page select changes once only after unlock key C5h.
`timescale 1ns/100ps
`default_nettype none
`include "led_dim_defines.svh"
module led_matrix_dimming_regs
  import led_dim_pkg::*;
#(
  parameter int SCAN_CYCLES = `T_SCAN_NS / `CLK_NS
)
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic detect_start_o,
  output logic detect_short_o,
  input wire logic fault_valid_i,
  input wire logic [`DOTS-1:0] fault_map_i,
  output logic [8:0] row_switch_o,
  output logic [`NCOL-1:0] column_sink_o,
  output logic [`NCOL*8-1:0] column_current_o,
  output logic run_not_shutdown_o,
  output logic input_threshold_select_o,
  output logic [2:0] row_pulldown_code_o,
  output logic [2:0] col_pullup_code_o
);
  localparam int NOL_CYCLES = `T_NOL_NS / `CLK_NS;
  localparam int STEP_CYCLES = SCAN_CYCLES / `PWM_STEPS;

  initial
  begin
    if (STEP_CYCLES < 1)
      $error("led_matrix_dimming_regs: slot shorter than 256 cycles");
  end

  // ************************************************************
  // Dot memories
  // ************************************************************
  logic [7:0] duty [`DOTS];
  logic [7:0] scal [`DOTS];

  regs_t r;
  regs_t next_r;
  logic [8:0] idx;
  logic idx_ok;
  logic wr_duty;
  logic wr_scal;
  logic soft_rst;
  logic [3:0] rows;
  logic steady;
  logic [3:0] row;
  logic active;
  logic [7:0] step;
  logic [8:0] base;
  logic [`NCOL-1:0] sink_on;
  logic [`NCOL*8-1:0] cur;

  // Pages 0/2 map straight to dots 0..179, pages 1/3 follow on
  always_comb
  begin
    idx = '0;
    idx_ok = 1'b0;
    case (r.page)
      `PG_DUTY_A, `PG_SCL_A:
      begin
        idx = {1'b0, reg_addr_i};
        idx_ok = reg_addr_i <= `LAST_A;
      end
      `PG_DUTY_B, `PG_SCL_B:
      begin
        idx = `DOTS_A + {1'b0, reg_addr_i};
        idx_ok = reg_addr_i <= `LAST_B;
      end
      default:
      begin
        idx = '0;
        idx_ok = 1'b0;
      end
    endcase
  end

  assign soft_rst = reg_wr_i && r.page == `PG_FN &&
    reg_addr_i == `A_RESET && reg_wdata_i == `RESET_KEY;
  assign wr_duty = reg_wr_i && idx_ok && r.page[2:1] == 2'b00;
  assign wr_scal = reg_wr_i && idx_ok && r.page[2:1] == 2'b01;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < `DOTS; i++)
      begin
        duty[i] <= 8'h00;
        scal[i] <= 8'h00;
      end
    end
    else if (soft_rst)
    begin
      for (int i = 0; i < `DOTS; i++)
      begin
        duty[i] <= 8'h00;
        scal[i] <= 8'h00;
      end
    end
    else
    begin
      if (wr_duty)
        duty[idx] <= reg_wdata_i;
      if (wr_scal)
        scal[idx] <= reg_wdata_i;
    end
  end

  // ************************************************************
  // Scan timing and per-column dimming
  // ************************************************************
  always_comb
  begin
    steady = 1'b0;
    rows = 4'd9;
    if (r.cfg[`CFG_SWS] == `SWS_STEADY)
      steady = 1'b1;
    else if (r.cfg[`CFG_SWS] != 4'h0 && r.cfg[`CFG_SWS] <= `SWS_MAX)
      rows = 4'd9 - r.cfg[`CFG_SWS];
  end

  scan_sequencer #(
    .SLOT(SCAN_CYCLES),
    .NOL(NOL_CYCLES),
    .STEP(STEP_CYCLES)
  ) u_scan (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .run_i(r.cfg[`CFG_RUN]),
    .rows_i(rows),
    .steady_i(steady),
    .row_o(row),
    .row_switch_o(row_switch_o),
    .active_o(active),
    .step_o(step)
  );

  assign base = 9'(row) * `NCOL_W;

  for (genvar c = 0; c < `NCOL; c++)
  begin : g_col
    logic [15:0] prod;
    assign sink_on[c] = active && step < duty[base + 9'(c)];
    assign prod = 16'(scal[base + 9'(c)]) * 16'(r.global_current);
    assign cur[c*8 +: 8] = prod[15:8];
  end

  // ************************************************************
  // Register file
  // ************************************************************
  function automatic logic [7:0] res_byte(input logic [`DOTS-1:0] f,
                                          input logic [7:0] a);
    logic [7:0] k;
    logic [8:0] b;
    logic [2:0] n;
    k = a - `A_RES_LO;
    b = 9'(k / `RES_PER_ROW) * `NCOL_W;
    n = 3'(k % `RES_PER_ROW);
    if (n == `RES_TAIL)
      res_byte = {1'b0, f[b + 9'd32 +: 7]};
    else
      res_byte = f[b + 9'({n, 3'b000}) +: 8];
  endfunction

  always_comb
  begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.sink = sink_on;
    next_r.cur = cur;
    if (reg_wr_i)
    begin
      if (reg_addr_i == `A_UNLOCK)
        next_r.unlock = reg_wdata_i;
      else if (reg_addr_i == `A_PAGE)
      begin
        // Out-of-range pages are refused but still use up the unlock
        if (r.unlock == `UNLOCK_KEY && reg_wdata_i <= 8'(`PG_FN))
          next_r.page = reg_wdata_i[2:0];
        next_r.unlock = 8'h00;
      end
      else if (r.page == `PG_FN)
        case (reg_addr_i)
          `A_CFG: next_r.cfg = reg_wdata_i;
          `A_GCC: next_r.global_current = reg_wdata_i;
          `A_PULL: next_r.pull = reg_wdata_i & `PULL_MASK;
          default: next_r.pull = r.pull;
        endcase
    end
    // Detection fires on the first nonzero field after it sat at 00
    if (r.cfg[`CFG_DET] == `DET_OFF)
      next_r.armed = 1'b1;
    else if (r.armed)
    begin
      next_r.armed = 1'b0;
      next_r.start = 1'b1;
    end
    if (soft_rst)
    begin
      next_r.page = `PG_DUTY_A;
      next_r.unlock = 8'h00;
      next_r.cfg = `CFG_RST;
      next_r.global_current = `GCC_RST;
      next_r.pull = `PULL_RST;
      next_r.fault = '0;
      next_r.armed = 1'b1;
      next_r.start = 1'b0;
    end
    // A result arriving with a soft reset is kept
    if (fault_valid_i)
      next_r.fault = fault_map_i;
    if (reg_rd_i)
    begin
      next_r.rdata = 8'h00;
      if (reg_addr_i == `A_UNLOCK)
        next_r.rdata = r.unlock;
      else if (idx_ok)
        next_r.rdata = r.page[1] ? scal[idx] : duty[idx];
      else if (r.page == `PG_FN)
      begin
        if (reg_addr_i == `A_CFG)
          next_r.rdata = r.cfg;
        else if (reg_addr_i == `A_GCC)
          next_r.rdata = r.global_current;
        else if (reg_addr_i == `A_PULL)
          next_r.rdata = r.pull;
        else if (reg_addr_i >= `A_RES_LO && reg_addr_i <= `A_RES_HI)
          next_r.rdata = res_byte(r.fault, reg_addr_i);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      r <= '{page: `PG_DUTY_A, cfg: `CFG_RST, global_current: `GCC_RST,
             pull: `PULL_RST, armed: 1'b1, default: '0};
    else
      r <= next_r;
  end

  assign reg_rdata_o = r.rdata;
  assign detect_start_o = r.start;
  assign detect_short_o = r.cfg[`CFG_DET] == `DET_SHORT;
  assign column_sink_o = r.sink;
  assign column_current_o = r.cur;
  assign run_not_shutdown_o = r.cfg[`CFG_RUN];
  assign input_threshold_select_o = r.cfg[`CFG_THR];
  assign row_pulldown_code_o = r.pull[`PULL_DN];
  assign col_pullup_code_o = r.pull[`PULL_UP];

  // ************************************************************
  // Checks
  // ************************************************************
  sequence page_write;
    reg_wr_i && reg_addr_i == `A_PAGE;
  endsequence

  sequence off3;
    !r.cfg[`CFG_RUN] [*3];
  endsequence

  lock_clear_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    page_write |=> r.unlock == 8'h00)
    else $error("unlock not cleared after page write");

  page_locked_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    page_write ##0 r.unlock != `UNLOCK_KEY |=> $stable(r.page))
    else $error("page changed while locked");

  soft_reset_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    soft_rst |=> r.cfg == `CFG_RST && r.pull == `PULL_RST &&
      r.global_current == `GCC_RST && r.page == `PG_DUTY_A)
    else $error("soft reset left a register off default");

  // A field back at 00 or a soft reset may legally rearm right away
  detect_once_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    r.start && !soft_rst && r.cfg[`CFG_DET] != `DET_OFF |=>
      !r.start && !r.armed)
    else $error("detection triggered twice");

  shutdown_dark_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    off3 |-> column_sink_o == '0 && row_switch_o == 9'h000)
    else $error("outputs active in shutdown");
endmodule
`default_nettype wire

// file: hw/scan_sequencer.sv
// Row scan sequencer: non-overlap gap, active slot, gap, next row.
// Assumes run, row count and steady mode come from registered config.
`timescale 1ns/100ps
`default_nettype none
module scan_sequencer
  import led_dim_pkg::*;
#(
  parameter int SLOT = 6400,
  parameter int NOL = 400,
  parameter int STEP = 25
)
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  input wire logic [3:0] rows_i,
  input wire logic steady_i,
  output logic [3:0] row_o,
  output logic [8:0] row_switch_o,
  output logic active_o,
  output logic [7:0] step_o
);
  initial
  begin
    if (STEP < 1 || STEP * `PWM_STEPS != SLOT || NOL < 1 || NOL > 65535)
      $error("scan_sequencer: slot must be 256 whole steps");
  end

  scan_t r;
  scan_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.cnt = r.cnt + 16'h0001;
    case (r.state)
      S_IDLE:
      begin
        next_r.cnt = '0;
        next_r.row = '0;
        if (run_i)
          next_r.state = S_GAP1;
      end
      S_GAP1:
        if (r.cnt == 16'(NOL - 1))
        begin
          next_r.state = S_SLOT;
          next_r.cnt = '0;
          next_r.step = '0;
          next_r.sw = steady_i ? 9'h000 : 9'(9'h001 << r.row);
        end
      S_SLOT:
        if (r.cnt == 16'(STEP - 1))
        begin
          next_r.cnt = '0;
          next_r.step = r.step + 8'h01;
          // Steady mode never leaves the slot: sinks run without gaps
          if (r.step == 8'hff && !steady_i)
          begin
            next_r.state = S_GAP2;
            next_r.sw = '0;
          end
        end
      S_GAP2:
        if (r.cnt == 16'(NOL - 1))
        begin
          next_r.state = S_GAP1;
          next_r.cnt = '0;
          next_r.row = (r.row + 4'h1 >= rows_i) ? 4'h0 : r.row + 4'h1;
        end
      default:
        next_r.state = S_IDLE;
    endcase
    if (!run_i)
    begin
      next_r.state = S_IDLE;
      next_r.sw = '0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      r <= '{state: S_IDLE, default: '0};
    else
      r <= next_r;
  end

  assign row_o = r.row;
  assign row_switch_o = r.sw;
  assign active_o = (r.state == S_SLOT);
  assign step_o = r.step;

  sequence gap1_end;
    r.state == S_GAP1 && r.cnt == 16'(NOL - 1) && run_i;
  endsequence

  sequence gap2_end;
    r.state == S_GAP2 && r.cnt == 16'(NOL - 1) && run_i;
  endsequence

  gap_dark_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    r.state != S_SLOT |-> r.sw == 9'h000)
    else $error("row switch on outside the slot");

  slot_start_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    gap1_end |=> r.state == S_SLOT && r.step == 8'h00)
    else $error("slot did not follow the first gap");

  row_wrap_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    gap2_end |=> r.state == S_GAP1 && r.row < rows_i &&
      (r.row == 4'h0 || r.row == $past(r.row) + 4'h1))
    else $error("row did not advance within the active count");
endmodule
`default_nettype wire

// file: test/fault_responder.sv
// Behavioural fault detection front end facing the dimming core.
// Assumes the bench hands it the fault pattern to report.
`timescale 1ns/100ps
`default_nettype none
`include "led_dim_defines.svh"
module fault_responder
#(
  parameter int DELAY = 5
)
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic detect_start_i,
  input wire logic [`DOTS-1:0] pattern_i,
  output logic fault_valid_o,
  output logic [`DOTS-1:0] fault_map_o
);
  // ****************
  // Delayed report
  // ****************
  int cnt;
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt <= 0;
      fault_valid_o <= 1'b0;
      fault_map_o <= '0;
    end
    else
    begin
      fault_valid_o <= (cnt == 1);
      // Map means nothing without valid, so keep it moving
      fault_map_o <= (cnt == 1) ? pattern_i : ~fault_map_o;
      if (detect_start_i)
        cnt <= DELAY;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the LED matrix dimming register core.
// Assumes hw/ on the include path and fault_responder as front end.
`timescale 1ns/100ps
`default_nettype none
`include "led_dim_defines.svh"
module testbench
  import led_dim_pkg::*;
;
  // ****************
  // Stimulus
  // ****************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic start, short_sel, fvalid, run, thr;
  logic [`DOTS-1:0] fmap;
  logic [`DOTS-1:0] pattern = '0;
  logic [8:0] rows;
  logic [`NCOL-1:0] sink;
  logic [`NCOL*8-1:0] cur;
  logic [2:0] pd, pu;
  logic [7:0] ma [4][5];
  logic [7:0] mv [4][5];
  logic [7:0] sv, gv, d;
  int n_fail = 0;
  int samples_checked = 0;
  int n_start = 0;
  int n0;

  always #2.5 clk = ~clk;
  always @(posedge clk)
    if (start === 1'b1)
      n_start++;

  led_matrix_dimming_regs #(.SCAN_CYCLES(256)) DUT (
    .mclk_i(clk), .arst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .detect_start_o(start), .detect_short_o(short_sel),
    .fault_valid_i(fvalid), .fault_map_i(fmap), .row_switch_o(rows),
    .column_sink_o(sink), .column_current_o(cur),
    .run_not_shutdown_o(run), .input_threshold_select_o(thr),
    .row_pulldown_code_o(pd), .col_pullup_code_o(pu));

  fault_responder fr (.mclk_i(clk), .arst_n_i(rst_n),
    .detect_start_i(start), .pattern_i(pattern),
    .fault_valid_o(fvalid), .fault_map_o(fmap));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] e);
    samples_checked++;
    if (got !== e)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, e);
    end
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = v;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    check(rdata, e);
  endtask

  task automatic page(input logic [7:0] p);
    wr8(8'hfe, 8'hc5);
    wr8(8'hfd, p);
  endtask

  function automatic logic [7:0] res_byte(input logic [`DOTS-1:0] m,
                                          input int k);
    int b;
    b = (k / 5) * 39 + (k % 5) * 8;
    if (k % 5 == 4)
      return {1'b0, m[b +: 7]};
    return m[b +: 8];
  endfunction

  task automatic det(input logic [7:0] v, input int p, input logic s);
    n0 = n_start;
    wr8(8'h00, v);
    repeat (3) @(negedge clk);
    check(n_start - n0, p);
    if (p == 1)
      check(short_sel, s);
  endtask

  // One scan period after a short settle, starting from shutdown
  task automatic scan(input logic [3:0] code);
    int p, ones, sw0, gap_on;
    logic [8:0] seen, e;
    e = (code == 0 || code > 8) ? 9'h1ff : (code == 8) ? 9'h000 :
        9'h1ff >> code;
    p = (code == 8) ? 256 : $countones(e) * 1056;
    wr8(8'h00, {code, 4'h1});
    // Steady mode still opens with one gap before the slot runs on
    repeat ((code == 8) ? 404 : 4) @(negedge clk);
    seen = '0;
    ones = 0;
    sw0 = 0;
    gap_on = 0;
    repeat (p)
    begin
      @(negedge clk);
      seen |= rows;
      // Column 0 of other rows is lit in their own slots
      ones += sink[0] & (rows[0] | code == 8);
      gap_on += sink[0] & (rows == 9'h000) & (code != 8);
      sw0 += rows[0];
    end
    check(seen, e);
    check(ones, d);
    check(gap_on, 0);
    check(sw0, (code == 8) ? 0 : 256);
    if (code == 8)
      check(cur[47:40], (sv * gv) >> 8);
    wr8(8'h00, 8'h00);
    repeat (3) @(negedge clk);
    check({rows, sink, run}, '0);
  endtask

  initial
  begin
    repeat (90000) @(negedge clk);
    n_fail++;
    $display("ERROR %0t run did not finish", $time);
    complete_run();
  end

  initial
  begin
    void'($urandom(62263));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    check({pd, pu, run, thr}, 8'hb4);
    wr8(8'hfd, 8'h04);
    wr8(8'h01, 8'h5a);
    page(8'h04);
    rdchk(8'h01, 8'h00);
    rdchk(8'h00, 8'h00);
    rdchk(8'h02, 8'h55);
    for (int k = 0; k < 45; k++)
      rdchk(8'(k + 3), 8'h00);
    page(8'h00);
    rdchk(8'h01, 8'h5a);
    for (int p = 0; p < 4; p++)
    begin
      page(8'(p));
      for (int i = 0; i < 5; i++)
      begin
        ma[p][i] = (i == 4) ? ((p % 2) ? 8'haa : 8'hb3) :
                   8'(i * 40 + $urandom_range(39));
        mv[p][i] = 8'($urandom);
        wr8(ma[p][i], mv[p][i]);
      end
      wr8(ma[p][4] + 8'h01, 8'hff);
    end
    for (int p = 0; p < 4; p++)
    begin
      page(8'(p));
      for (int i = 0; i < 5; i++)
        rdchk(ma[p][i], mv[p][i]);
      rdchk(ma[p][4] + 8'h01, 8'h00);
    end
    page(8'h04);
    wr8(8'h02, 8'hff);
    rdchk(8'h02, 8'h77);
    check({pd, pu}, 6'h3f);
    wr8(8'h00, 8'h08);
    check(thr, 1'b1);
    wr8(8'h00, 8'h00);
    for (int i = 0; i < 10; i++)
      pattern[i * 32 +: 32] = $urandom;
    pattern[`DOTS-1:320] = 31'($urandom);
    det(8'h02, 1, 1'b0);
    repeat (10) @(negedge clk);
    for (int k = 0; k < 45; k++)
      rdchk(8'(k + 3), res_byte(pattern, k));
    det(8'h04, 0, 1'b0);
    det(8'h00, 0, 1'b0);
    det(8'h04, 1, 1'b1);
    det(8'h00, 0, 1'b0);
    det(8'h06, 1, 1'b0);
    det(8'h00, 0, 1'b0);
    sv = 8'($urandom);
    gv = 8'($urandom);
    page(8'h02);
    wr8(8'h05, sv);
    page(8'h04);
    wr8(8'h01, gv);
    for (int c = 0; c < 10; c++)
    begin
      d = 8'($urandom_range(255, 1));
      page(8'h00);
      wr8(8'h00, d);
      page(8'h04);
      scan(4'(c));
    end
    wr8(8'h3f, 8'hae);
    rdchk(8'h00, 8'h00);
    page(8'h04);
    rdchk(8'h01, 8'h00);
    rdchk(8'h02, 8'h55);
    complete_run();
  end
endmodule
`default_nettype wire
